// >>> core/ubr_bridge.sv
// usb-uart bridge: uart, flow control, buffers, usb state, indicator pins and resets
`timescale 1ns/100ps
`include "ubr_map.svh"

//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - bit divisor is int(12 MHz / rate)
// - host rate request applies new divisor
// - rts low while able to receive
// - rts high at 63 waiting characters
// - cts checked just before each character
// - started character always completes
// - full receive buffer: pointer holds, last slot overwritten
// - separate 64-byte transmit and receive buffers
// - suspend signalling enters suspend
// - resume, bus reset or reset exits suspend
// - over 3 ms idle means suspend
// - suspend pin low while suspended
// - configured pin low until configured
// - configured pin low during suspend
// - in traffic: pulse low or toggle
// - out traffic: pulse low or toggle
// - eight pins individually input or output
// - held in reset while reset pin low
// - short reset glitches are filtered out
// - power-on reset pulse initialises logic
// - reset default 19200 8N1
// - rate request changes rate only
// - flow control enabled by stored bit
// - traffic indicators are active low
module ubr_bridge #(
	parameter int BUF_DEPTH = `UBR_BUF_DEPTH,
	parameter int DIV_W = 24,
	parameter int SUSP_CYC = `UBR_SUSP_CYC,
	parameter int LED_FAST_CYC = `UBR_LED_FAST_CYC,
	parameter int LED_SLOW_CYC = `UBR_LED_SLOW_CYC
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic ext_rst_b,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic uart_rx,
	output logic uart_tx,
	input wire logic cts_n,
	output logic rts_n,
	input wire logic [7:0] usb_out_data,
	input wire logic usb_out_valid,
	output logic usb_out_ready,
	output logic [7:0] usb_in_data,
	output logic usb_in_valid,
	input wire logic usb_in_ready,
	input wire logic usb_lc_valid,
	input wire logic [31:0] usb_lc_rate,
	input wire logic usb_activity,
	input wire logic usb_resume,
	input wire logic usb_bus_reset,
	input wire logic usb_config_done,
	input wire logic host_in_msg,
	input wire logic host_out_msg,
	input wire logic [7:0] port_pin_in,
	output logic [7:0] port_pin_out,
	output logic [7:0] port_pin_oe
);
	import ubr_pkg::*;
	localparam int PW = $clog2(BUF_DEPTH);
	localparam int CW = PW + 1;
	localparam logic [CW-1:0] FULL = CW'(BUF_DEPTH);

	//////////////////////////////////////////////////////////////////////////
	// reset generation
	logic [7:0] filt_ff, nxt_filt, por_ff, nxt_por;
	logic ext_hold_ff, nxt_ext_hold, core_rst_n_ff, nxt_core_rst_n;

	// glitch filter needs a full window of low before holding reset
	always_comb
	begin
		nxt_filt = 8'h00;
		nxt_ext_hold = 1'b0;
		nxt_por = por_ff;
		if (!ext_rst_b)
		begin
			nxt_filt = (filt_ff == 8'(`UBR_RST_FILT_CYC)) ? filt_ff : filt_ff + 8'h01;
			nxt_ext_hold = (filt_ff == 8'(`UBR_RST_FILT_CYC));
		end
		if (por_ff != 8'(`UBR_POR_CYC))
			nxt_por = por_ff + 8'h01;
		nxt_core_rst_n = (por_ff == 8'(`UBR_POR_CYC)) && !nxt_ext_hold;
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			filt_ff <= 8'h00;
			ext_hold_ff <= 1'b0;
			por_ff <= 8'h00;
			core_rst_n_ff <= 1'b0;
		end
		else
		begin
			filt_ff <= nxt_filt;
			ext_hold_ff <= nxt_ext_hold;
			por_ff <= nxt_por;
			core_rst_n_ff <= nxt_core_rst_n;
		end
	end

	a_rst_hold_pin: assert property (@(posedge ref_clk) disable iff (!rst_b)
		ext_hold_ff |-> !core_rst_n_ff) else $error("core left reset while pin held");

	//////////////////////////////////////////////////////////////////////////
	// register file and rate divider
	logic [`UBR_CFG_W-1:0] cfg_ff, nxt_cfg;
	logic [7:0] dir_ff, nxt_dir, gout_ff, nxt_gout;
	logic [31:0] rdata_ff, nxt_rdata, rate_ff, nxt_rate, rem_ff, nxt_rem;
	logic [DIV_W-1:0] div_ff, nxt_div, dvd_ff, nxt_dvd, quo_ff, nxt_quo;
	logic [4:0] step_ff, nxt_step;
	logic busy_ff, nxt_busy, flow_en;
	logic [31:0] rem_sh;
	logic susp_ff, cfgd_ff;
	logic [CW-1:0] rxb_cnt_ff, txb_cnt_ff;

	assign flow_en = cfg_ff[`UBR_CFG_FLOW];
	assign rem_sh = {rem_ff[30:0], dvd_ff[DIV_W-1]};

	// writes, reads and the restoring divider for the bit divisor
	always_comb
	begin
		nxt_cfg = cfg_ff;
		nxt_dir = dir_ff;
		nxt_gout = gout_ff;
		nxt_rate = rate_ff;
		nxt_rem = rem_ff;
		nxt_dvd = dvd_ff;
		nxt_quo = quo_ff;
		nxt_step = step_ff;
		nxt_busy = busy_ff;
		nxt_div = div_ff;
		nxt_rdata = 32'h0000_0000;
		if (reg_wr && reg_addr == `UBR_OFS_CFG)
			nxt_cfg = reg_wdata[`UBR_CFG_W-1:0];
		else if (reg_wr && reg_addr == `UBR_OFS_DIR)
			nxt_dir = reg_wdata[7:0];
		else if (reg_wr && reg_addr == `UBR_OFS_OUT)
			nxt_gout = reg_wdata[7:0];
		// host or software rate request; nothing but rate changes
		if (usb_lc_valid && usb_lc_rate != 32'h0000_0000)
			nxt_rate = usb_lc_rate;
		else if (reg_wr && reg_addr == `UBR_OFS_RATE && reg_wdata != 32'h0000_0000)
			nxt_rate = reg_wdata;
		if (nxt_rate != rate_ff)
		begin
			nxt_busy = 1'b1;
			nxt_step = 5'h00;
			nxt_rem = 32'h0000_0000;
			nxt_quo = '0;
			nxt_dvd = DIV_W'(`UBR_REF_HZ);
		end
		// truncating division, one quotient bit a cycle
		else if (busy_ff)
		begin
			nxt_dvd = {dvd_ff[DIV_W-2:0], 1'b0};
			nxt_rem = (rem_sh >= rate_ff) ? rem_sh - rate_ff : rem_sh;
			nxt_quo = {quo_ff[DIV_W-2:0], rem_sh >= rate_ff};
			nxt_step = step_ff + 5'h01;
			if (step_ff == 5'(DIV_W - 1))
			begin
				nxt_busy = 1'b0;
				nxt_div = (nxt_quo == '0) ? DIV_W'(1) : nxt_quo;
			end
		end
		// unmapped addresses read as zero
		if (reg_rd && reg_addr == `UBR_OFS_CFG)
			nxt_rdata = 32'(cfg_ff);
		else if (reg_rd && reg_addr == `UBR_OFS_DIR)
			nxt_rdata = {24'h00_0000, dir_ff};
		else if (reg_rd && reg_addr == `UBR_OFS_OUT)
			nxt_rdata = {24'h00_0000, gout_ff};
		else if (reg_rd && reg_addr == `UBR_OFS_IN)
			nxt_rdata = {24'h00_0000, port_pin_in};
		else if (reg_rd && reg_addr == `UBR_OFS_RATE)
			nxt_rdata = rate_ff;
		else if (reg_rd && reg_addr == `UBR_OFS_DIV)
			nxt_rdata = 32'(div_ff);
		else if (reg_rd && reg_addr == `UBR_OFS_STAT)
			nxt_rdata = {7'h00, busy_ff, 8'(txb_cnt_ff), 8'(rxb_cnt_ff), 6'h00, cfgd_ff, susp_ff};
	end

	always_ff @(posedge ref_clk or negedge core_rst_n_ff)
	begin
		if (!core_rst_n_ff)
		begin
			cfg_ff <= `UBR_CFG_RST;
			dir_ff <= `UBR_DIR_RST;
			gout_ff <= `UBR_OUT_RST;
			rdata_ff <= 32'h0000_0000;
			rate_ff <= 32'(`UBR_DEF_RATE);
			div_ff <= DIV_W'(`UBR_DEF_DIV);
			rem_ff <= 32'h0000_0000;
			dvd_ff <= '0;
			quo_ff <= '0;
			step_ff <= 5'h00;
			busy_ff <= 1'b0;
		end
		else
		begin
			cfg_ff <= nxt_cfg;
			dir_ff <= nxt_dir;
			gout_ff <= nxt_gout;
			rdata_ff <= nxt_rdata;
			rate_ff <= nxt_rate;
			div_ff <= nxt_div;
			rem_ff <= nxt_rem;
			dvd_ff <= nxt_dvd;
			quo_ff <= nxt_quo;
			step_ff <= nxt_step;
			busy_ff <= nxt_busy;
		end
	end

	// finished divisor matches the truncated quotient
	a_div_value: assert property (@(posedge ref_clk) disable iff (!core_rst_n_ff)
		$fell(busy_ff) |-> 32'(div_ff) == ((`UBR_REF_HZ / rate_ff) == 0 ? 32'd1 :
		`UBR_REF_HZ / rate_ff)) else $error("bit divisor wrong");

	//////////////////////////////////////////////////////////////////////////
	// 12 MHz enable and uart engines
	logic [6:0] acc_ff, nxt_acc;
	logic ref_tick;
	ubr_tx_state_t tx_st_ff, nxt_tx_st;
	ubr_rx_state_t rx_st_ff, nxt_rx_st;
	logic [9:0] tx_sh_ff, nxt_tx_sh;
	logic [3:0] tx_bit_ff, nxt_tx_bit, rx_bit_ff, nxt_rx_bit;
	logic [DIV_W-1:0] tx_cnt_ff, nxt_tx_cnt, rx_cnt_ff, nxt_rx_cnt;
	logic [7:0] rx_sh_ff, nxt_rx_sh;
	logic [7:0] txb_mem [BUF_DEPTH];
	logic [PW-1:0] txb_rp_ff;
	logic tx_pop, rx_push;

	// fractional accumulator: 12 ticks per 100 clocks, exact on average
	assign ref_tick = (acc_ff + 7'(`UBR_REF_STEP)) >= 7'(`UBR_REF_WRAP);
	assign nxt_acc = ref_tick ? acc_ff + 7'(`UBR_REF_STEP) - 7'(`UBR_REF_WRAP) :
		acc_ff + 7'(`UBR_REF_STEP);

	// transmitter
	always_comb
	begin
		nxt_tx_st = tx_st_ff;
		nxt_tx_sh = tx_sh_ff;
		nxt_tx_bit = tx_bit_ff;
		nxt_tx_cnt = tx_cnt_ff;
		tx_pop = 1'b0;
		case (tx_st_ff)
			TX_IDLE:
				// cts sampled right before loading; ignored with flow off
				if (txb_cnt_ff != '0 && (!flow_en || !cts_n))
				begin
					tx_pop = 1'b1;
					nxt_tx_sh = {1'b1, txb_mem[txb_rp_ff], 1'b0};
					nxt_tx_st = TX_SHIFT;
					nxt_tx_cnt = '0;
					nxt_tx_bit = 4'h0;
				end
			TX_SHIFT:
				// no look at cts once started
				if (ref_tick && tx_cnt_ff == div_ff - DIV_W'(1))
				begin
					nxt_tx_cnt = '0;
					nxt_tx_sh = {1'b1, tx_sh_ff[9:1]};
					nxt_tx_bit = tx_bit_ff + 4'h1;
					if (tx_bit_ff == 4'h9)
						nxt_tx_st = TX_IDLE;
				end
				else if (ref_tick)
					nxt_tx_cnt = tx_cnt_ff + DIV_W'(1);
			default:
				nxt_tx_st = TX_IDLE;
		endcase
	end

	// receiver: checks start at half a bit, then samples each bit centre
	always_comb
	begin
		nxt_rx_st = rx_st_ff;
		nxt_rx_sh = rx_sh_ff;
		nxt_rx_bit = rx_bit_ff;
		nxt_rx_cnt = (ref_tick && rx_st_ff != RX_IDLE) ? rx_cnt_ff + DIV_W'(1) : rx_cnt_ff;
		rx_push = 1'b0;
		case (rx_st_ff)
			RX_IDLE:
				if (!uart_rx)
				begin
					nxt_rx_st = RX_START;
					nxt_rx_cnt = '0;
				end
			RX_START:
				if (ref_tick && rx_cnt_ff == (div_ff >> 1))
				begin
					nxt_rx_cnt = '0;
					nxt_rx_bit = 4'h0;
					nxt_rx_st = uart_rx ? RX_IDLE : RX_DATA;
				end
			RX_DATA:
				if (ref_tick && rx_cnt_ff == div_ff - DIV_W'(1))
				begin
					nxt_rx_cnt = '0;
					nxt_rx_sh = {uart_rx, rx_sh_ff[7:1]};
					nxt_rx_bit = rx_bit_ff + 4'h1;
					if (rx_bit_ff == 4'h7)
						nxt_rx_st = RX_STOP;
				end
			RX_STOP:
				// a character with a low stop bit is dropped as a framing error
				if (ref_tick && rx_cnt_ff == div_ff - DIV_W'(1))
				begin
					rx_push = uart_rx;
					nxt_rx_st = RX_IDLE;
				end
			default:
				nxt_rx_st = RX_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge core_rst_n_ff)
	begin
		if (!core_rst_n_ff)
		begin
			acc_ff <= 7'h00;
			tx_st_ff <= TX_IDLE;
			tx_sh_ff <= 10'h3ff;
			tx_bit_ff <= 4'h0;
			tx_cnt_ff <= '0;
			rx_st_ff <= RX_IDLE;
			rx_sh_ff <= 8'h00;
			rx_bit_ff <= 4'h0;
			rx_cnt_ff <= '0;
		end
		else
		begin
			acc_ff <= nxt_acc;
			tx_st_ff <= nxt_tx_st;
			tx_sh_ff <= nxt_tx_sh;
			tx_bit_ff <= nxt_tx_bit;
			tx_cnt_ff <= nxt_tx_cnt;
			rx_st_ff <= nxt_rx_st;
			rx_sh_ff <= nxt_rx_sh;
			rx_bit_ff <= nxt_rx_bit;
			rx_cnt_ff <= nxt_rx_cnt;
		end
	end

	sequence s_tx_load;
		tx_st_ff == TX_IDLE ##1 tx_st_ff == TX_SHIFT;
	endsequence

	// a character starts only with cts low or flow off
	a_cts_gate: assert property (@(posedge ref_clk) disable iff (!core_rst_n_ff)
		s_tx_load |-> $past(!cts_n || !flow_en)) else $error("started without cts");
	// line drops to the start bit as a character begins
	a_tx_start_bit: assert property (@(posedge ref_clk) disable iff (!core_rst_n_ff)
		s_tx_load |-> !uart_tx) else $error("no start bit");
	// character runs to its stop bit
	a_tx_no_abort: assert property (@(posedge ref_clk) disable iff (!core_rst_n_ff)
		tx_st_ff == TX_SHIFT && tx_bit_ff < 4'h9 |=> tx_st_ff == TX_SHIFT)
		else $error("character cut short");

	//////////////////////////////////////////////////////////////////////////
	// transmit and receive character buffers
	logic [7:0] rxb_mem [BUF_DEPTH];
	logic [PW-1:0] txb_wp_ff, nxt_txb_wp, nxt_txb_rp, rxb_wp_ff, nxt_rxb_wp;
	logic [PW-1:0] rxb_rp_ff, nxt_rxb_rp, rxb_waddr;
	logic [CW-1:0] nxt_txb_cnt, nxt_rxb_cnt;
	logic out_rdy_ff, nxt_out_rdy, in_vld_ff, nxt_in_vld, rts_n_ff, nxt_rts_n;
	logic [7:0] in_dat_ff, nxt_in_dat;
	logic txb_push, rxb_pop, rxb_we;

	always_comb
	begin
		txb_push = usb_out_valid && out_rdy_ff;
		nxt_txb_wp = txb_wp_ff + PW'(txb_push);
		nxt_txb_rp = txb_rp_ff + PW'(tx_pop);
		nxt_txb_cnt = txb_cnt_ff + CW'(txb_push) - CW'(tx_pop);
		// ready is honest: it looks at the count after this cycle
		nxt_out_rdy = nxt_txb_cnt != FULL;
		rxb_pop = rxb_cnt_ff != '0 && (!in_vld_ff || usb_in_ready);
		nxt_in_vld = rxb_pop ? 1'b1 : (in_vld_ff && !usb_in_ready);
		nxt_in_dat = rxb_pop ? rxb_mem[rxb_rp_ff] : in_dat_ff;
		nxt_rxb_rp = rxb_rp_ff + PW'(rxb_pop);
		rxb_we = rx_push;
		rxb_waddr = rxb_wp_ff;
		nxt_rxb_wp = rxb_wp_ff;
		nxt_rxb_cnt = rxb_cnt_ff - CW'(rxb_pop);
		// when full the pointer holds and the last slot is overwritten
		if (rx_push && (rxb_cnt_ff != FULL || rxb_pop))
		begin
			nxt_rxb_wp = rxb_wp_ff + PW'(1);
			nxt_rxb_cnt = rxb_cnt_ff;
			if (!rxb_pop)
				nxt_rxb_cnt = rxb_cnt_ff + CW'(1);
		end
		else if (rx_push)
			rxb_waddr = rxb_wp_ff - PW'(1);
		// rts low while room, high at the trip point
		nxt_rts_n = nxt_cfg[`UBR_CFG_FLOW] && nxt_rxb_cnt >= CW'(`UBR_RTS_TRIP);
	end

	// buffer storage carries no reset: contents only matter behind the counts
	always_ff @(posedge ref_clk)
	begin
		if (txb_push)
			txb_mem[txb_wp_ff] <= usb_out_data;
		if (rxb_we)
			rxb_mem[rxb_waddr] <= rx_sh_ff;
	end

	always_ff @(posedge ref_clk or negedge core_rst_n_ff)
	begin
		if (!core_rst_n_ff)
		begin
			txb_wp_ff <= '0;
			txb_rp_ff <= '0;
			txb_cnt_ff <= '0;
			out_rdy_ff <= 1'b0;
			rxb_wp_ff <= '0;
			rxb_rp_ff <= '0;
			rxb_cnt_ff <= '0;
			in_vld_ff <= 1'b0;
			in_dat_ff <= 8'h00;
			rts_n_ff <= 1'b0;
		end
		else
		begin
			txb_wp_ff <= nxt_txb_wp;
			txb_rp_ff <= nxt_txb_rp;
			txb_cnt_ff <= nxt_txb_cnt;
			out_rdy_ff <= nxt_out_rdy;
			rxb_wp_ff <= nxt_rxb_wp;
			rxb_rp_ff <= nxt_rxb_rp;
			rxb_cnt_ff <= nxt_rxb_cnt;
			in_vld_ff <= nxt_in_vld;
			in_dat_ff <= nxt_in_dat;
			rts_n_ff <= nxt_rts_n;
		end
	end

	a_rts_trip: assert property (@(posedge ref_clk) disable iff (!core_rst_n_ff)
		flow_en && rxb_cnt_ff >= CW'(`UBR_RTS_TRIP) |-> rts_n_ff)
		else $error("rts low above trip point");
	a_rts_ready: assert property (@(posedge ref_clk) disable iff (!core_rst_n_ff)
		rxb_cnt_ff < CW'(`UBR_RTS_TRIP) |-> !rts_n_ff) else $error("rts high with room");
	// overflow leaves pointer and count alone
	a_rx_hold: assert property (@(posedge ref_clk) disable iff (!core_rst_n_ff)
		rxb_cnt_ff == FULL && rx_push && !rxb_pop |=> rxb_wp_ff == $past(rxb_wp_ff)
		&& rxb_cnt_ff == FULL) else $error("full pointer moved");

	//////////////////////////////////////////////////////////////////////////
	// usb state, traffic indicators and port pins
	logic [31:0] idle_ff, nxt_idle;
	logic nxt_susp, nxt_cfgd;
	logic [1:0] lvl_ff, nxt_lvl;
	logic [31:0] led_ff [2];
	logic [31:0] nxt_led [2];
	logic [7:0] pin_out_ff, nxt_pin_out, pin_oe_ff, nxt_pin_oe;
	logic [1:0] msg;
	ubr_led_mode_t mode [2];

	assign msg = {host_out_msg, host_in_msg};
	assign mode[0] = ubr_led_mode_t'(cfg_ff[`UBR_CFG_INLED_LO +: 2]);
	assign mode[1] = ubr_led_mode_t'(cfg_ff[`UBR_CFG_OUTLED_LO +: 2]);

	always_comb
	begin
		nxt_idle = idle_ff;
		nxt_susp = susp_ff;
		nxt_cfgd = cfgd_ff;
		// idle for 3 ms is suspend signalling
		if (usb_activity || usb_resume || usb_bus_reset)
			nxt_idle = 32'h0000_0000;
		else if (!susp_ff && idle_ff == 32'(SUSP_CYC - 1))
			nxt_susp = 1'b1;
		else if (!susp_ff)
			nxt_idle = idle_ff + 32'h0000_0001;
		// resume or bus reset leaves suspend
		if (usb_resume || usb_bus_reset)
			nxt_susp = 1'b0;
		// configured only after the host says so; a same-cycle set wins
		if (usb_config_done)
			nxt_cfgd = 1'b1;
		else if (usb_bus_reset)
			nxt_cfgd = 1'b0;
		// pulse low for the chosen time, or toggle per message
		for (int i = 0; i < 2; i++)
		begin
			nxt_led[i] = (led_ff[i] != 32'h0000_0000) ? led_ff[i] - 32'h0000_0001 : led_ff[i];
			nxt_lvl[i] = lvl_ff[i];
			if (msg[i] && mode[i] == LED_TOGGLE)
				nxt_lvl[i] = !lvl_ff[i];
			else if (msg[i] && mode[i] == LED_SLOW)
				nxt_led[i] = 32'(LED_SLOW_CYC);
			else if (msg[i] && mode[i] == LED_FAST)
				nxt_led[i] = 32'(LED_FAST_CYC);
			if (mode[i] != LED_TOGGLE)
				nxt_lvl[i] = (nxt_led[i] == 32'h0000_0000);
		end
		// pins follow direction unless taken by an indicator
		nxt_pin_oe = dir_ff;
		nxt_pin_out = gout_ff;
		if (cfg_ff[`UBR_CFG_SUSP_EN])
		begin
			nxt_pin_oe[0] = 1'b1;
			nxt_pin_out[0] = !nxt_susp;
		end
		if (cfg_ff[`UBR_CFG_USB_CONFIGURED_INDICATOR_EN])
		begin
			nxt_pin_oe[1] = 1'b1;
			nxt_pin_out[1] = nxt_cfgd && !nxt_susp;
		end
		// active-low traffic indicators on pins 6 and 7
		if (mode[0] != LED_OFF)
		begin
			nxt_pin_oe[6] = 1'b1;
			nxt_pin_out[6] = nxt_lvl[0];
		end
		if (mode[1] != LED_OFF)
		begin
			nxt_pin_oe[7] = 1'b1;
			nxt_pin_out[7] = nxt_lvl[1];
		end
	end

	always_ff @(posedge ref_clk or negedge core_rst_n_ff)
	begin
		if (!core_rst_n_ff)
		begin
			idle_ff <= 32'h0000_0000;
			susp_ff <= 1'b0;
			cfgd_ff <= 1'b0;
			lvl_ff <= 2'h3;
			led_ff[0] <= 32'h0000_0000;
			led_ff[1] <= 32'h0000_0000;
			pin_out_ff <= 8'h00;
			pin_oe_ff <= 8'h00;
		end
		else
		begin
			idle_ff <= nxt_idle;
			susp_ff <= nxt_susp;
			cfgd_ff <= nxt_cfgd;
			lvl_ff <= nxt_lvl;
			led_ff[0] <= nxt_led[0];
			led_ff[1] <= nxt_led[1];
			pin_out_ff <= nxt_pin_out;
			pin_oe_ff <= nxt_pin_oe;
		end
	end

	// idle limit enters suspend next cycle
	a_susp_enter: assert property (@(posedge ref_clk) disable iff (!core_rst_n_ff)
		!susp_ff && idle_ff == 32'(SUSP_CYC - 1) && !usb_activity && !usb_resume
		&& !usb_bus_reset |=> susp_ff) else $error("idle did not suspend");
	// resume or bus reset ends suspend
	a_susp_exit: assert property (@(posedge ref_clk) disable iff (!core_rst_n_ff)
		susp_ff && (usb_resume || usb_bus_reset) |=> !susp_ff) else $error("stuck suspended");
	a_cfg_pin_susp: assert property (@(posedge ref_clk) disable iff (!core_rst_n_ff)
		susp_ff && cfg_ff[`UBR_CFG_USB_CONFIGURED_INDICATOR_EN] && !usb_resume && !usb_bus_reset
		|=> !pin_out_ff[1])
		else $error("configured pin high in suspend");

	//////////////////////////////////////////////////////////////////////////
	// outputs straight from flip-flops
	assign reg_rdata = rdata_ff;
	assign uart_tx = tx_sh_ff[0];
	assign rts_n = rts_n_ff;
	assign usb_out_ready = out_rdy_ff;
	assign usb_in_valid = in_vld_ff;
	assign usb_in_data = in_dat_ff;
	assign port_pin_out = pin_out_ff;
	assign port_pin_oe = pin_oe_ff;
endmodule

// >>> core/ubr_map.svh
// constants of the usb-uart bridge: clock figures, offsets, fields, reset values, timings
`ifndef UBR_MAP_SVH
`define UBR_MAP_SVH
`define UBR_CLK_HZ 100000000
`define UBR_CLK_PERIOD_NS (1000000000 / `UBR_CLK_HZ)
`define UBR_REF_HZ 12000000
`define UBR_REF_STEP (`UBR_REF_HZ / 1000000)
`define UBR_REF_WRAP (`UBR_CLK_HZ / 1000000)
`define UBR_DEF_RATE 19200
`define UBR_DEF_DIV (`UBR_REF_HZ / `UBR_DEF_RATE)
`define UBR_BUF_DEPTH 64
`define UBR_RTS_TRIP 63
`define UBR_CYC_PER_MS (`UBR_CLK_HZ / 1000)
`define UBR_SUSP_MS 3
`define UBR_SUSP_CYC (`UBR_SUSP_MS * `UBR_CYC_PER_MS)
`define UBR_LED_FAST_MS 100
`define UBR_LED_FAST_CYC (`UBR_LED_FAST_MS * `UBR_CYC_PER_MS)
`define UBR_LED_SLOW_MS 200
`define UBR_LED_SLOW_CYC (`UBR_LED_SLOW_MS * `UBR_CYC_PER_MS)
`define UBR_RST_FILT_NS 1000
`define UBR_RST_FILT_CYC ((`UBR_RST_FILT_NS + `UBR_CLK_PERIOD_NS - 1) / `UBR_CLK_PERIOD_NS)
`define UBR_POR_NS 500
`define UBR_POR_CYC ((`UBR_POR_NS + `UBR_CLK_PERIOD_NS - 1) / `UBR_CLK_PERIOD_NS)
`define UBR_OFS_CFG 8'h00
`define UBR_OFS_DIR 8'h04
`define UBR_OFS_OUT 8'h08
`define UBR_OFS_IN 8'h0c
`define UBR_OFS_RATE 8'h10
`define UBR_OFS_DIV 8'h14
`define UBR_OFS_STAT 8'h18
`define UBR_CFG_FLOW 0
`define UBR_CFG_SUSP_EN 1
`define UBR_CFG_USB_CONFIGURED_INDICATOR_EN 2
`define UBR_CFG_INLED_LO 3
`define UBR_CFG_OUTLED_LO 5
`define UBR_CFG_W 7
`define UBR_CFG_RST 7'h00
`define UBR_DIR_RST 8'h00
`define UBR_OUT_RST 8'h00
`endif

// >>> core/ubr_pkg.sv
// types of the usb-uart bridge
package ubr_pkg;
	typedef enum logic [1:0] {LED_OFF, LED_TOGGLE, LED_SLOW, LED_FAST} ubr_led_mode_t;
	typedef enum logic {TX_IDLE, TX_SHIFT} ubr_tx_state_t;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} ubr_rx_state_t;
endpackage

// >>> verification/ubr_peer.sv
// uart peer model: serial sender and checking receiver
`timescale 1ns/100ps
module ubr_peer #(
	parameter real BIT_NS = 333.3
) (
	input wire logic uart_tx,
	output logic uart_rx
);
	logic [7:0] got;
	int rx_cnt;
	// line idles high, like a pulled-up wire
	initial
	begin
		uart_rx = 1'b1;
		got = 8'h00;
		rx_cnt = 0;
	end
	always @(negedge uart_tx)
	begin
		#(BIT_NS * 1.5);
		for (int i = 0; i < 8; i++)
		begin
			got[i] = uart_tx;
			#(BIT_NS);
		end
		if (uart_tx === 1'b1)
			rx_cnt++;
	end
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			uart_rx = f[i];
			#(BIT_NS);
		end
	endtask
endmodule

// >>> verification/tb_usb_uart_flow_and_status_pins.sv
// self-checking bench of the usb-uart bridge
`timescale 1ns/100ps
`include "ubr_map.svh"
module tb_usb_uart_flow_and_status_pins;
	logic ref_clk, rst_b, ext_rst_b, reg_wr, reg_rd, uart_rx, uart_tx, cts_n, rts_n, t;
	logic [7:0] reg_addr, usb_out_data, usb_in_data, port_pin_out, port_pin_oe;
	logic [31:0] reg_wdata, reg_rdata, usb_lc_rate, v;
	logic usb_out_valid, usb_out_ready, usb_in_valid, usb_in_ready, usb_lc_valid, usb_activity;
	logic [4:0] ev;
	int fails, checks_done, cyc, n;
	logic [31:0] rows [7][4] = '{'{`UBR_OFS_RATE, 38400, `UBR_OFS_DIV, 312},
		'{`UBR_OFS_RATE, 0, `UBR_OFS_DIV, 312}, '{`UBR_OFS_RATE, 1000000, `UBR_OFS_DIV, 12},
		'{`UBR_OFS_DIR, 8'h0f, `UBR_OFS_DIR, 8'h0f}, '{8'h20, 8'hff, 8'h20, 0},
		'{`UBR_OFS_IN, 8'hff, `UBR_OFS_IN, 8'h3c},
		'{`UBR_OFS_OUT, 8'ha5, `UBR_OFS_OUT, 8'ha5}};
	// short idle and pulse counts keep the run brief
	ubr_bridge #(.SUSP_CYC(50), .LED_FAST_CYC(20), .LED_SLOW_CYC(40)) uut (.ref_clk(ref_clk),
		.rst_b(rst_b), .ext_rst_b(ext_rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .uart_rx(uart_rx),
		.uart_tx(uart_tx), .cts_n(cts_n), .rts_n(rts_n), .usb_out_data(usb_out_data),
		.usb_out_valid(usb_out_valid), .usb_out_ready(usb_out_ready), .usb_in_data(usb_in_data),
		.usb_in_valid(usb_in_valid), .usb_in_ready(usb_in_ready), .usb_lc_valid(usb_lc_valid),
		.usb_lc_rate(usb_lc_rate), .usb_activity(usb_activity), .usb_resume(ev[2]),
		.usb_bus_reset(ev[4]), .usb_config_done(ev[3]), .host_in_msg(ev[1]),
		.host_out_msg(ev[0]), .port_pin_in(8'h3c), .port_pin_out(port_pin_out),
		.port_pin_oe(port_pin_oe));
	ubr_peer #(.BIT_NS(4000.0 / 12.0)) peer (.uart_tx(uart_tx), .uart_rx(uart_rx));
	//////////////////////////////////////////////////////////////////////////////
	// clock
	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// hang guard
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 90000)
		begin
			fails++;
			report_and_stop();
		end
	end
	task chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e)
		begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task waitc(input int c);
		repeat (c) @(posedge ref_clk);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	// read data stands only in the cycle after the strobe
	task rd(input logic [7:0] a);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	task pulse(input logic [4:0] m);
		@(posedge ref_clk);
		ev <= m;
		@(posedge ref_clk);
		ev <= 5'h00;
	endtask
	// byte held until the buffer takes it
	task push(input logic [7:0] b);
		@(posedge ref_clk);
		usb_out_data <= b;
		usb_out_valid <= 1'b1;
		@(posedge ref_clk);
		while (usb_out_ready !== 1'b1) @(posedge ref_clk);
		usb_out_valid <= 1'b0;
	endtask
	task report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	//////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		{rst_b, reg_wr, reg_rd, usb_out_valid, usb_in_ready, usb_lc_valid, cts_n} = 7'h01;
		{ext_rst_b, usb_activity, reg_addr, reg_wdata, usb_out_data, usb_lc_rate} = 82'h3 << 80;
		{ev, fails, checks_done, cyc} = 0;
		waitc(20);
		rst_b <= 1'b1;
		waitc(60);
		rd(`UBR_OFS_DIV);
		chk(v, 625);
		chk({rts_n, uart_tx, usb_out_ready}, 3'b011);
		$display("test reset done");
		for (int i = 0; i < 7; i++)
		begin
			wr(rows[i][0][7:0], rows[i][1]);
			waitc(30);
			rd(rows[i][2][7:0]);
			chk(v, rows[i][3]);
		end
		chk({port_pin_oe, port_pin_out}, 16'h0fa5);
		@(posedge ref_clk);
		usb_lc_rate <= 3000000;
		usb_lc_valid <= 1'b1;
		@(posedge ref_clk);
		usb_lc_valid <= 1'b0;
		waitc(30);
		rd(`UBR_OFS_DIV);
		chk(v, 4);
		$display("test rate done");
		wr(`UBR_OFS_CFG, 1);
		n = peer.rx_cnt;
		push(8'h5a);
		waitc(400);
		chk(peer.rx_cnt - n, 0);
		// clear-to-send dropped again in mid-character
		cts_n <= 1'b0;
		waitc(100);
		cts_n <= 1'b1;
		waitc(400);
		chk(peer.got, 8'h5a);
		wr(`UBR_OFS_CFG, 0);
		push(8'ha5);
		waitc(450);
		chk(peer.got, 8'ha5);
		$display("test tx done");
		wr(`UBR_OFS_CFG, 1);
		n = 0;
		while (rts_n === 1'b0 && n < 70)
		begin
			peer.send(n[7:0]);
			n++;
		end
		waitc(2);
		rd(`UBR_OFS_STAT);
		chk(v[15:8], 63);
		chk({usb_in_valid, usb_in_data}, 9'h100);
		// flow off: the second extra byte lands on the last slot
		wr(`UBR_OFS_CFG, 0);
		peer.send(8'hc3);
		peer.send(8'h3c);
		wr(`UBR_OFS_CFG, 1);
		rd(`UBR_OFS_STAT);
		chk(v[15:8], 64);
		chk(rts_n, 1);
		usb_in_ready <= 1'b1;
		waitc(200);
		chk(rts_n, 0);
		chk(usb_in_data, 8'h3c);
		$display("test rx done");
		wr(`UBR_OFS_CFG, 32'h3e);
		pulse(5'h08);
		waitc(3);
		chk(port_pin_out[1:0], 2'b11);
		usb_activity <= 1'b0;
		waitc(60);
		chk(port_pin_out[1:0], 2'b00);
		pulse(5'h04);
		waitc(3);
		chk(port_pin_out[1:0], 2'b11);
		waitc(60);
		chk(port_pin_out[1:0], 2'b00);
		// bus reset leaves suspend and drops the configured state
		pulse(5'h10);
		waitc(3);
		chk(port_pin_out[1:0], 2'b01);
		usb_activity <= 1'b1;
		pulse(5'h02);
		waitc(5);
		chk(port_pin_out[6], 0);
		waitc(30);
		chk(port_pin_out[6], 1);
		t = port_pin_out[7];
		pulse(5'h01);
		waitc(3);
		chk(port_pin_out[7], !t);
		// slow pulse outlasts the fast one
		wr(`UBR_OFS_CFG, 32'h5e);
		pulse(5'h01);
		waitc(30);
		chk(port_pin_out[7], 0);
		waitc(20);
		chk(port_pin_out[7], 1);
		$display("test status done");
		ext_rst_b <= 1'b0;
		waitc(50);
		ext_rst_b <= 1'b1;
		waitc(5);
		rd(`UBR_OFS_CFG);
		chk(v, 32'h5e);
		ext_rst_b <= 1'b0;
		waitc(150);
		ext_rst_b <= 1'b1;
		waitc(60);
		rd(`UBR_OFS_CFG);
		chk(v, 0);
		$display("test reset pin done");
		report_and_stop();
	end
endmodule
